// >>> sim/bjx_exec_sva.sv
// Purpose: Concurrent checks on the execute slice ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Results are expected one cycle after the taking edge; the byte load write-back two cycles after.
`timescale 1ns/1ps
`include "bjx_exec_regs.vh"

module bjx_exec_sva (
  input logic        clk_sys,
  input logic        reset_n,
  input logic        op_valid,
  input logic        op_ready,
  input logic [5:0]  op_code,
  input logic [31:0] op_pc,
  input logic [31:0] op_src_a,
  input logic [31:0] op_src_b,
  input logic [15:0] op_offset,
  input logic        mode_16bit,
  input logic [7:0]  mem_rdata,
  input logic        wb_en,
  input logic [4:0]  wb_addr,
  input logic [31:0] wb_data,
  input logic        pc_load,
  input logic [31:0] pc_target,
  input logic        slot_annul,
  input logic        slot_skip,
  input logic        hazards_clear,
  input logic [31:0] status_reg,
  input logic        mem_rd,
  input logic        div_by_zero
);
  wire        take   = op_valid && op_ready;
  wire [31:0] br_tgt = op_pc + `BJX_SLOT_OFS + {{14{op_offset[15]}}, op_offset, 2'b00};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_gez_likely: assert property (take && op_code == `BJX_OP_BR_GEZ_LIKELY |=>
    slot_annul == $past(op_src_a[31]) && pc_load == !$past(op_src_a[31]))
    else $error("gez likely branch outcome wrong");
  a_gtz_plain: assert property (take && op_code == `BJX_OP_BR_GTZ |=>
    !slot_annul && pc_load == (!$past(op_src_a[31]) && $past(op_src_a) != 0))
    else $error("gtz branch outcome wrong");
  a_lez_likely: assert property (take && op_code == `BJX_OP_BR_LEZ_LIKELY |=>
    slot_annul == !($past(op_src_a[31]) || $past(op_src_a) == 0))
    else $error("lez likely annul wrong");
  a_ltz_target: assert property (take && op_code == `BJX_OP_BR_LTZ && op_src_a[31] |=>
    pc_load && pc_target == $past(br_tgt))
    else $error("ltz branch target wrong");
  a_ltz_link: assert property (take && (op_code == `BJX_OP_BR_LTZ_LINK ||
    op_code == `BJX_OP_BR_LTZ_LINK_LIKELY) |=> wb_en && wb_addr == `BJX_LINK_REG_NUM &&
    wb_data == $past(op_pc) + `BJX_LINK_OFS_DELAY)
    else $error("ltz link write wrong");
  a_bne_taken: assert property (take && op_code == `BJX_OP_BR_NOT_EQUAL |=>
    pc_load == ($past(op_src_a) != $past(op_src_b)))
    else $error("not equal branch outcome wrong");
  a_jump_link_reg_link: assert property (take && op_code == `BJX_OP_JUMP_LINK_REG |=>
    pc_load && pc_target == $past(op_src_a) && wb_data == $past(op_pc) + `BJX_LINK_OFS_DELAY)
    else $error("jump link register wrong");
  a_compact_skip: assert property (take && op_code == `BJX_OP_JUMP_REG_COMPACT && mode_16bit |=>
    slot_skip && pc_target == $past(op_src_a))
    else $error("compact jump wrong");
  a_irq_disable: assert property (take && op_code == `BJX_OP_IRQ_DISABLE_ATOMIC |=>
    !status_reg[`BJX_SR_IE_BIT] && wb_data == $past(status_reg))
    else $error("irq disable wrong");
  a_byte_load: assert property (take && op_code == `BJX_OP_LOAD_BYTE_SIGNED |=>
    mem_rd && !op_ready ##1 wb_en && wb_data == {{24{$past(mem_rdata[7])}}, $past(mem_rdata)})
    else $error("byte load wrong");
  a_barrier_hold: assert property (take && op_code == `BJX_OP_EXEC_HAZARD_BARRIER |=>
    !op_ready [*3])
    else $error("barrier released early");

  c_annul: cover property (slot_annul);
  c_skip: cover property (slot_skip);
  c_hazard: cover property (hazards_clear);
  c_divzero: cover property (div_by_zero);
endmodule // bjx_exec_sva

bind bjx_exec bjx_exec_sva u_sva (.clk_sys, .reset_n, .op_valid, .op_ready, .op_code, .op_pc,
  .op_src_a, .op_src_b, .op_offset, .mode_16bit, .mem_rdata, .wb_en, .wb_addr, .wb_data,
  .pc_load, .pc_target, .slot_annul, .slot_skip, .hazards_clear, .status_reg, .mem_rd,
  .div_by_zero);

// >>> sim/bjx_exec_tb.sv
// Purpose: Self-checking bench for the execute slice.
// Assumes: Inputs change at the falling edge; results read one cycle later, load and coprocessor data two.
// Notes:   Expected values are worked out here from the operands.
`timescale 1ns/1ps
`include "bjx_exec_regs.vh"

module bjx_exec_tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        op_valid = 1'b0;
  logic [5:0]  op_code = 6'h00;
  logic [31:0] op_pc = 32'h0000_1000;
  logic [31:0] op_src_a = 32'h0000_0000;
  logic [31:0] op_src_b = 32'h0000_0000;
  logic [15:0] op_offset = 16'hfffe;
  logic [4:0]  op_dest = 5'h05;
  logic [4:0]  op_pos = 5'h04;
  logic [4:0]  op_size = 5'h07;
  logic [4:0]  op_ccr_sel = 5'h03;
  logic        mode_16bit = 1'b0;
  logic        hazard_pending = 1'b0;
  logic [7:0]  mem_rdata = 8'h85;
  logic [31:0] copro2_rdata = 32'h2468_ace0;
  logic [31:0] av [4] = '{32'h0000_0000, 32'h0000_0001, 32'h8000_0000, 32'hffff_ffff};
  logic [2:0]  e;
  integer      errors = 0;
  integer      comparisons = 0;
  integer      cycles = 0;
  integer      i;
  integer      k;
  wire         op_ready, wb_en, pc_load, slot_annul, slot_skip, hazards_clear;
  wire         load_linked_flag, debug_mode, mem_rd, copro2_wr, copro2_rd, div_by_zero;
  wire [4:0]   wb_addr, copro2_sel;
  wire [31:0]  wb_data, pc_target, result_low_reg, result_high_reg, status_reg;
  wire [31:0]  debug_return_pc, exception_return_pc, error_return_pc, mem_addr, copro2_wdata;

  bjx_exec dut (.clk_sys, .reset_n, .op_valid, .op_code, .op_pc, .op_src_a, .op_src_b,
    .op_offset, .op_dest, .op_pos, .op_size, .op_ccr_sel, .mode_16bit, .hazard_pending,
    .mem_rdata, .copro2_rdata, .op_ready, .wb_en, .wb_addr, .wb_data, .pc_load, .pc_target,
    .slot_annul, .slot_skip, .hazards_clear, .result_low_reg, .result_high_reg, .status_reg,
    .load_linked_flag, .debug_mode, .debug_return_pc, .exception_return_pc, .error_return_pc,
    .mem_rd, .mem_addr, .copro2_wr, .copro2_rd, .copro2_sel, .copro2_wdata, .div_by_zero);

  always #50 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Lets one edge pass with no op, offers one op, and returns at the falling edge after it
  // is taken, so that op_valid is never lowered and raised again in one time step.
  task automatic run_op(input logic [5:0] c, input logic [31:0] a, input logic [31:0] b);
    integer n;
    n = 0;
    @(negedge clk_sys);
    while (op_ready !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    op_code = c;
    op_src_a = a;
    op_src_b = b;
    op_valid = 1'b1;
    @(negedge clk_sys);
    op_valid = 1'b0;
  endtask

  // Returns taken, likely and link flags of a branch code.
  function automatic logic [2:0] br_exp(input logic [5:0] c, input logic [31:0] a);
    case (c)
      `BJX_OP_BR_GEZ_LINK_LIKELY: br_exp = {!a[31], 2'b11};
      `BJX_OP_BR_GEZ_LIKELY: br_exp = {!a[31], 2'b10};
      `BJX_OP_BR_GTZ: br_exp = {!a[31] && a != 0, 2'b00};
      `BJX_OP_BR_GTZ_LIKELY: br_exp = {!a[31] && a != 0, 2'b10};
      `BJX_OP_BR_LEZ: br_exp = {a[31] || a == 0, 2'b00};
      `BJX_OP_BR_LEZ_LIKELY: br_exp = {a[31] || a == 0, 2'b10};
      `BJX_OP_BR_LTZ: br_exp = {a[31], 2'b00};
      `BJX_OP_BR_LTZ_LINK: br_exp = {a[31], 2'b01};
      `BJX_OP_BR_LTZ_LINK_LIKELY: br_exp = {a[31], 2'b11};
      `BJX_OP_BR_NOT_EQUAL: br_exp = {a != 32'h0000_0001, 2'b00};
      default: br_exp = {a != 32'h0000_0001, 2'b10};
    endcase
  endfunction

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    chk("status reset", status_reg, `BJX_SR_RESET);
    for (i = 1; i <= 11; i++) begin
      for (k = 0; k < 4; k++) begin
        run_op(i[5:0], av[k], 32'h0000_0001);
        e = br_exp(i[5:0], av[k]);
        chk("branch load", pc_load, e[2]);
        chk("branch annul", slot_annul, e[1] & ~e[2]);
        chk("branch link", wb_en, e[0]);
        if (e[2])
          chk("branch target", pc_target, 32'h0000_0ffc);
        if (e[0])
          chk("link value", wb_data, 32'h0000_1008);
      end
    end
    run_op(`BJX_OP_COUNT_LEAD_ZEROES, 32'h00f0_0000, 32'h0000_0000);
    chk("clz", wb_data, 32'h0000_0008);
    run_op(`BJX_OP_COUNT_LEAD_ZEROES, 32'h0000_0000, 32'h0000_0000);
    chk("clz zero", wb_data, 32'h0000_0020);
    run_op(`BJX_OP_COUNT_LEAD_ONES, 32'hff0f_0000, 32'h0000_0000);
    chk("clo", wb_data, 32'h0000_0008);
    run_op(`BJX_OP_DIVIDE_SIGNED, 32'hffff_fff9, 32'h0000_0002);
    chk("div q", result_low_reg, 32'hffff_fffd);
    chk("div r", result_high_reg, 32'hffff_ffff);
    run_op(`BJX_OP_DIVIDE_UNSIGNED, 32'hffff_fff9, 32'h0000_0002);
    chk("divide_unsigned q", result_low_reg, 32'h7fff_fffc);
    chk("divide_unsigned r", result_high_reg, 32'h0000_0001);
    run_op(`BJX_OP_DIVIDE_UNSIGNED, 32'h0000_0005, 32'h0000_0000);
    chk("div zero", {div_by_zero, result_low_reg[30:0]}, 32'h8000_0000);
    run_op(`BJX_OP_IRQ_ENABLE_ATOMIC, 32'h0000_0000, 32'h0000_0000);
    chk("ei old", wb_data, 32'h0000_0004);
    chk("ei status", status_reg, 32'h0000_0005);
    run_op(`BJX_OP_IRQ_DISABLE_ATOMIC, 32'h0000_0000, 32'h0000_0000);
    chk("di old", wb_data, 32'h0000_0005);
    chk("di status", status_reg, 32'h0000_0004);
    run_op(`BJX_OP_EXCEPTION_RETURN, 32'h0000_0000, 32'h0000_0000);
    chk("exception_return err pc", pc_target, 32'h0000_0000);
    chk("exception_return load", pc_load, 1'b1);
    chk("exception_return status", status_reg, 32'h0000_0000);
    chk("exception_return ll", load_linked_flag, 1'b0);
    run_op(`BJX_OP_EXCEPTION_RETURN, 32'h0000_0000, 32'h0000_0000);
    chk("exception_return pc", {pc_load, pc_target[30:0]}, 32'h8000_0000);
    op_pc = 32'h0000_2000;
    run_op(`BJX_OP_DEBUG_ENTRY, 32'h0000_0000, 32'h0000_0000);
    chk("debug pc", debug_return_pc, 32'h0000_2000);
    chk("debug mode", debug_mode, 1'b1);
    op_pc = 32'h0000_1000;
    run_op(`BJX_OP_DEBUG_RETURN, 32'h0000_0000, 32'h0000_0000);
    chk("debug_return pc", pc_target, 32'h0000_2000);
    chk("debug_return mode", debug_mode, 1'b0);
    run_op(`BJX_OP_FIELD_EXTRACT, 32'h1234_5678, 32'h0000_0000);
    chk("extract", wb_data, 32'h0000_0067);
    op_pos = 5'h08;
    op_size = 5'h0f;
    run_op(`BJX_OP_FIELD_INSERT, 32'h0000_00ab, 32'hffff_ffff);
    chk("insert", wb_data, 32'hffff_abff);
    run_op(`BJX_OP_COPRO2_CTRL_WRITE, 32'h0000_0000, 32'h1357_9bdf);
    chk("cp2 wr", {copro2_wr, copro2_sel, copro2_wdata[25:0]}, 32'h8f57_9bdf);
    run_op(`BJX_OP_COPRO2_CTRL_READ, 32'h0000_0000, 32'h0000_0000);
    chk("cp2 rd", copro2_rd, 1'b1);
    @(negedge clk_sys);
    chk("cp2 data", wb_data, 32'h2468_ace0);
    op_offset = 16'hfffc;
    run_op(`BJX_OP_LOAD_BYTE_SIGNED, 32'h0000_0100, 32'h0000_0000);
    chk("lb addr", mem_addr, 32'h0000_00fc);
    @(negedge clk_sys);
    chk("lb data", wb_data, 32'hffff_ff85);
    run_op(`BJX_OP_JUMP_LINK_REG, 32'h0000_3000, 32'h0000_0000);
    chk("jump_link_reg", {wb_addr, slot_skip, wb_data[25:0]}, 32'h2800_1008);
    run_op(`BJX_OP_JUMP_LINK_REG_BARRIER, 32'h0000_3000, 32'h0000_0000);
    chk("jump_link_reg_barrier", hazards_clear, 1'b1);
    run_op(`BJX_OP_JUMP_REG_BARRIER, 32'h0000_3004, 32'h0000_0000);
    chk("jump_reg_barrier", {hazards_clear, pc_target[30:0]}, 32'h8000_3004);
    mode_16bit = 1'b1;
    run_op(`BJX_OP_JUMP_LINK_REG_COMPACT, 32'h0000_3000, 32'h0000_0000);
    chk("jump_link_reg_compact", {slot_skip, wb_data[30:0]}, 32'h8000_1002);
    run_op(`BJX_OP_JUMP_REG_COMPACT, 32'h0000_3008, 32'h0000_0000);
    chk("jrc", {slot_skip, pc_load, wb_en, pc_target[28:0]}, 32'hc000_3008);
    mode_16bit = 1'b0;
    run_op(`BJX_OP_JUMP_REG_COMPACT, 32'h0000_3000, 32'h0000_0000);
    chk("jrc off", pc_load, 1'b0);
    hazard_pending = 1'b1;
    run_op(`BJX_OP_EXEC_HAZARD_BARRIER, 32'h0000_0000, 32'h0000_0000);
    repeat (5) @(negedge clk_sys);
    chk("ehb wait", {op_ready, hazards_clear}, 2'b00);
    hazard_pending = 1'b0;
    k = 0;
    while (hazards_clear !== 1'b1 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    chk("ehb done", hazards_clear, 1'b1);
    give_verdict();
  end
endmodule // bjx_exec_tb

// >>> verilog/bjx_exec.v
// Purpose: Execute stage for branches, register jumps, returns and special ops.
// Assumes: Operands already read; one op accepted per cycle while ready is high.
// Notes:   Results appear one cycle after the op is accepted; byte load writes back two cycles after, coprocessor read too if no op taken next drives wb_en.
`timescale 1ns/1ps
`include "bjx_exec_regs.vh"

module bjx_exec (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        op_valid,
  input  wire [5:0]  op_code,
  input  wire [31:0] op_pc,
  input  wire [31:0] op_src_a,
  input  wire [31:0] op_src_b,
  input  wire [15:0] op_offset,
  input  wire [4:0]  op_dest,
  input  wire [4:0]  op_pos,
  input  wire [4:0]  op_size,
  input  wire [4:0]  op_ccr_sel,
  input  wire        mode_16bit,
  input  wire        hazard_pending,
  input  wire [7:0]  mem_rdata,
  input  wire [31:0] copro2_rdata,
  output reg         op_ready,
  output reg         wb_en,
  output reg  [4:0]  wb_addr,
  output reg  [31:0] wb_data,
  output reg         pc_load,
  output reg  [31:0] pc_target,
  output reg         slot_annul,
  output reg         slot_skip,
  output reg         hazards_clear,
  output reg  [31:0] result_low_reg,
  output reg  [31:0] result_high_reg,
  output reg  [31:0] status_reg,
  output reg         load_linked_flag,
  output reg         debug_mode,
  output reg  [31:0] debug_return_pc,
  output reg  [31:0] exception_return_pc,
  output reg  [31:0] error_return_pc,
  output reg         mem_rd,
  output reg  [31:0] mem_addr,
  output reg         copro2_wr,
  output reg         copro2_rd,
  output reg  [4:0]  copro2_sel,
  output reg  [31:0] copro2_wdata,
  output reg         div_by_zero
);

  localparam ST_RUN   = 3'b001;
  localparam ST_LOAD  = 3'b010;
  localparam ST_HOLD  = 3'b100;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [2:0]  hold_cnt_reg;
  reg [4:0]  load_dest_reg;
  reg        cp_rd_pend_reg;
  reg [4:0]  cp_dest_reg;

  wire        take = op_valid & op_ready;
  wire        sign_a = op_src_a[31];
  wire        zero_a = (op_src_a == 32'h0000_0000);
  wire [31:0] slot_pc = op_pc + `BJX_SLOT_OFS;
  wire [31:0] br_tgt = slot_pc + {{14{op_offset[15]}}, op_offset, 2'b00};
  wire [31:0] link8 = op_pc + `BJX_LINK_OFS_DELAY;
  wire [31:0] link2 = op_pc + `BJX_LINK_OFS_COMPACT;

  ////////////////////////////////////////////////////////////////////////////

  // Leading zero counts of the operand and of its inverse.
  reg [5:0] clz_cnt;
  reg [5:0] clo_cnt;
  reg       clz_done;
  reg       clo_done;
  integer   i;
  always @* begin
    clz_cnt  = 6'h20;
    clo_cnt  = 6'h20;
    clz_done = 1'b0;
    clo_done = 1'b0;
    for (i = 31; i >= 0; i = i - 1) begin
      if (!clz_done && op_src_a[i]) begin
        clz_cnt  = 6'd31 - i[5:0];
        clz_done = 1'b1;
      end
      if (!clo_done && !op_src_a[i]) begin
        clo_cnt  = 6'd31 - i[5:0];
        clo_done = 1'b1;
      end
    end
  end

  // Field masks: extract takes size+1 bits from pos; insert spans pos..size.
  wire [31:0] ext_mask = (op_size == 5'h1f) ? 32'hffff_ffff :
                         ((32'h0000_0001 << (op_size + 5'h01)) - 32'h0000_0001);
  wire [31:0] ext_val = (op_src_a >> op_pos) & ext_mask;
  wire [4:0]  ins_w = op_size - op_pos;
  wire [31:0] ins_low = (ins_w == 5'h1f) ? 32'hffff_ffff :
                        ((32'h0000_0001 << (ins_w + 5'h01)) - 32'h0000_0001);
  wire [31:0] ins_mask = ins_low << op_pos;
  wire [31:0] ins_val = (op_src_b & ~ins_mask) | ((op_src_a << op_pos) & ins_mask);

  // Divide, signed on magnitudes with sign fix-up.
  wire [31:0] mag_a = (sign_a) ? (32'h0000_0000 - op_src_a) : op_src_a;
  wire [31:0] mag_b = (op_src_b[31]) ? (32'h0000_0000 - op_src_b) : op_src_b;
  wire        div_zero = (op_src_b == 32'h0000_0000);
  wire [31:0] uq = div_zero ? 32'h0000_0000 : op_src_a / op_src_b;
  wire [31:0] ur = div_zero ? 32'h0000_0000 : op_src_a % op_src_b;
  wire [31:0] mq = div_zero ? 32'h0000_0000 : mag_a / mag_b;
  wire [31:0] mr = div_zero ? 32'h0000_0000 : mag_a % mag_b;
  wire [31:0] sq = (sign_a ^ op_src_b[31]) ? (32'h0000_0000 - mq) : mq;
  wire [31:0] sr = sign_a ? (32'h0000_0000 - mr) : mr;

  ////////////////////////////////////////////////////////////////////////////

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (take && op_code == `BJX_OP_LOAD_BYTE_SIGNED)
          state_next = ST_LOAD;
        else if (take && op_code == `BJX_OP_EXEC_HAZARD_BARRIER)
          state_next = ST_HOLD;
      end
      ST_LOAD: state_next = ST_RUN;
      ST_HOLD: begin
        if (!hazard_pending && hold_cnt_reg == 3'h0)
          state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg           <= ST_RUN;
      hold_cnt_reg        <= 3'h0;
      load_dest_reg       <= 5'h00;
      cp_rd_pend_reg      <= 1'b0;
      cp_dest_reg         <= 5'h00;
      op_ready            <= 1'b0;
      wb_en               <= 1'b0;
      wb_addr             <= 5'h00;
      wb_data             <= 32'h0000_0000;
      pc_load             <= 1'b0;
      pc_target           <= 32'h0000_0000;
      slot_annul          <= 1'b0;
      slot_skip           <= 1'b0;
      hazards_clear       <= 1'b0;
      result_low_reg      <= 32'h0000_0000;
      result_high_reg     <= 32'h0000_0000;
      status_reg          <= `BJX_SR_RESET;
      load_linked_flag    <= 1'b0;
      debug_mode          <= 1'b0;
      debug_return_pc     <= 32'h0000_0000;
      exception_return_pc <= 32'h0000_0000;
      error_return_pc     <= 32'h0000_0000;
      mem_rd              <= 1'b0;
      mem_addr            <= 32'h0000_0000;
      copro2_wr           <= 1'b0;
      copro2_rd           <= 1'b0;
      copro2_sel          <= 5'h00;
      copro2_wdata        <= 32'h0000_0000;
      div_by_zero         <= 1'b0;
    end else begin
      state_reg      <= state_next;
      op_ready       <= (state_next == ST_RUN);
      wb_en          <= 1'b0;
      pc_load        <= 1'b0;
      slot_annul     <= 1'b0;
      slot_skip      <= 1'b0;
      hazards_clear  <= 1'b0;
      mem_rd         <= 1'b0;
      copro2_wr      <= 1'b0;
      copro2_rd      <= 1'b0;
      div_by_zero    <= 1'b0;
      cp_rd_pend_reg <= 1'b0;
      if (state_reg == ST_HOLD) begin
        if (hold_cnt_reg != 3'h0)
          hold_cnt_reg <= hold_cnt_reg - 3'h1;
        if (state_next == ST_RUN)
          hazards_clear <= 1'b1;
      end
      if (state_reg == ST_LOAD) begin
        wb_en   <= 1'b1;
        wb_addr <= load_dest_reg;
        wb_data <= {{24{mem_rdata[7]}}, mem_rdata};
      end
      if (cp_rd_pend_reg) begin
        wb_en   <= 1'b1;
        wb_addr <= cp_dest_reg;
        wb_data <= copro2_rdata;
      end
      if (take) begin
        case (op_code)
          `BJX_OP_BR_GEZ_LINK_LIKELY: begin
            wb_en      <= 1'b1;
            wb_addr    <= `BJX_LINK_REG_NUM;
            wb_data    <= link8;
            pc_load    <= !sign_a;
            pc_target  <= br_tgt;
            slot_annul <= sign_a;
          end
          `BJX_OP_BR_GEZ_LIKELY: begin
            pc_load    <= !sign_a;
            pc_target  <= br_tgt;
            slot_annul <= sign_a;
          end
          `BJX_OP_BR_GTZ, `BJX_OP_BR_GTZ_LIKELY: begin
            pc_load    <= !sign_a && !zero_a;
            pc_target  <= br_tgt;
            slot_annul <= (op_code == `BJX_OP_BR_GTZ_LIKELY) && (sign_a || zero_a);
          end
          `BJX_OP_BR_LEZ, `BJX_OP_BR_LEZ_LIKELY: begin
            pc_load    <= sign_a || zero_a;
            pc_target  <= br_tgt;
            slot_annul <= (op_code == `BJX_OP_BR_LEZ_LIKELY) && !sign_a && !zero_a;
          end
          `BJX_OP_BR_LTZ: begin
            pc_load   <= sign_a;
            pc_target <= br_tgt;
          end
          `BJX_OP_BR_LTZ_LINK, `BJX_OP_BR_LTZ_LINK_LIKELY: begin
            wb_en      <= 1'b1;
            wb_addr    <= `BJX_LINK_REG_NUM;
            wb_data    <= link8;
            pc_load    <= sign_a;
            pc_target  <= br_tgt;
            slot_annul <= (op_code == `BJX_OP_BR_LTZ_LINK_LIKELY) && !sign_a;
          end
          `BJX_OP_BR_NOT_EQUAL, `BJX_OP_BR_NOT_EQUAL_LIKELY: begin
            pc_load    <= (op_src_a != op_src_b);
            pc_target  <= br_tgt;
            slot_annul <= (op_code == `BJX_OP_BR_NOT_EQUAL_LIKELY) &&
                          (op_src_a == op_src_b);
          end
          `BJX_OP_COPRO2_CTRL_READ: begin
            copro2_rd      <= 1'b1;
            copro2_sel     <= op_ccr_sel;
            cp_rd_pend_reg <= 1'b1;
            cp_dest_reg    <= op_dest;
          end
          `BJX_OP_COPRO2_CTRL_WRITE: begin
            copro2_wr    <= 1'b1;
            copro2_sel   <= op_ccr_sel;
            copro2_wdata <= op_src_b;
          end
          `BJX_OP_COUNT_LEAD_ONES, `BJX_OP_COUNT_LEAD_ZEROES: begin
            wb_en   <= 1'b1;
            wb_addr <= op_dest;
            wb_data <= {26'h000_0000, (op_code == `BJX_OP_COUNT_LEAD_ONES) ?
                        clo_cnt : clz_cnt};
          end
          `BJX_OP_DEBUG_RETURN: begin
            pc_load    <= 1'b1;
            pc_target  <= debug_return_pc;
            debug_mode <= 1'b0;
          end
          `BJX_OP_DEBUG_ENTRY: begin
            debug_return_pc <= op_pc;
            debug_mode      <= 1'b1;
          end
          `BJX_OP_IRQ_DISABLE_ATOMIC, `BJX_OP_IRQ_ENABLE_ATOMIC: begin
            wb_en   <= 1'b1;
            wb_addr <= op_dest;
            wb_data <= status_reg;
            status_reg[`BJX_SR_IE_BIT] <= (op_code == `BJX_OP_IRQ_ENABLE_ATOMIC);
          end
          `BJX_OP_DIVIDE_SIGNED, `BJX_OP_DIVIDE_UNSIGNED: begin
            div_by_zero <= div_zero;
            if (op_code == `BJX_OP_DIVIDE_SIGNED) begin
              result_low_reg  <= sq;
              result_high_reg <= sr;
            end else begin
              result_low_reg  <= uq;
              result_high_reg <= ur;
            end
          end
          `BJX_OP_EXEC_HAZARD_BARRIER: hold_cnt_reg <= `BJX_HAZARD_CYCLES;
          `BJX_OP_EXCEPTION_RETURN: begin
            pc_load <= 1'b1;
            if (status_reg[`BJX_SR_ERL_BIT]) begin
              pc_target <= error_return_pc;
              status_reg[`BJX_SR_ERL_BIT] <= 1'b0;
            end else begin
              pc_target <= exception_return_pc;
              status_reg[`BJX_SR_EXL_BIT] <= 1'b0;
            end
            load_linked_flag <= 1'b0;
          end
          `BJX_OP_FIELD_EXTRACT: begin
            wb_en   <= 1'b1;
            wb_addr <= op_dest;
            wb_data <= ext_val;
          end
          `BJX_OP_FIELD_INSERT: begin
            wb_en   <= 1'b1;
            wb_addr <= op_dest;
            wb_data <= ins_val;
          end
          `BJX_OP_JUMP_LINK_REG, `BJX_OP_JUMP_LINK_REG_BARRIER: begin
            wb_en         <= 1'b1;
            wb_addr       <= op_dest;
            wb_data       <= link8;
            pc_load       <= 1'b1;
            pc_target     <= op_src_a;
            hazards_clear <= (op_code == `BJX_OP_JUMP_LINK_REG_BARRIER);
          end
          `BJX_OP_JUMP_REG, `BJX_OP_JUMP_REG_BARRIER: begin
            pc_load       <= 1'b1;
            pc_target     <= op_src_a;
            hazards_clear <= (op_code == `BJX_OP_JUMP_REG_BARRIER);
          end
          `BJX_OP_JUMP_LINK_REG_COMPACT, `BJX_OP_JUMP_REG_COMPACT: begin
            if (mode_16bit) begin
              wb_en     <= (op_code == `BJX_OP_JUMP_LINK_REG_COMPACT);
              wb_addr   <= op_dest;
              wb_data   <= link2;
              pc_load   <= 1'b1;
              pc_target <= op_src_a;
              slot_skip <= 1'b1;
            end
          end
          `BJX_OP_LOAD_BYTE_SIGNED: begin
            mem_rd        <= 1'b1;
            mem_addr      <= op_src_a + {{16{op_offset[15]}}, op_offset};
            load_dest_reg <= op_dest;
          end
          default: ;
        endcase
      end
    end
  end

endmodule // bjx_exec

// >>> verilog/bjx_exec_regs.vh
// Purpose: Constants for the branch, jump and special-op execute slice.
// Assumes: 32-bit datapath, one operation code presented per cycle.
// Notes:   Operation codes are a local encoding of this block.
`ifndef BJX_EXEC_REGS_VH
`define BJX_EXEC_REGS_VH

`define BJX_OP_NOP                 6'h00
`define BJX_OP_BR_GEZ_LINK_LIKELY  6'h01
`define BJX_OP_BR_GEZ_LIKELY       6'h02
`define BJX_OP_BR_GTZ              6'h03
`define BJX_OP_BR_GTZ_LIKELY       6'h04
`define BJX_OP_BR_LEZ              6'h05
`define BJX_OP_BR_LEZ_LIKELY       6'h06
`define BJX_OP_BR_LTZ              6'h07
`define BJX_OP_BR_LTZ_LINK         6'h08
`define BJX_OP_BR_LTZ_LINK_LIKELY  6'h09
`define BJX_OP_BR_NOT_EQUAL        6'h0a
`define BJX_OP_BR_NOT_EQUAL_LIKELY 6'h0b
`define BJX_OP_COPRO2_CTRL_READ    6'h0c
`define BJX_OP_COPRO2_CTRL_WRITE   6'h0d
`define BJX_OP_COUNT_LEAD_ONES     6'h0e
`define BJX_OP_COUNT_LEAD_ZEROES   6'h0f
`define BJX_OP_DEBUG_RETURN        6'h10
`define BJX_OP_IRQ_DISABLE_ATOMIC  6'h11
`define BJX_OP_IRQ_ENABLE_ATOMIC   6'h12
`define BJX_OP_DIVIDE_SIGNED       6'h13
`define BJX_OP_DIVIDE_UNSIGNED     6'h14
`define BJX_OP_EXEC_HAZARD_BARRIER 6'h15
`define BJX_OP_EXCEPTION_RETURN    6'h16
`define BJX_OP_FIELD_EXTRACT       6'h17
`define BJX_OP_FIELD_INSERT        6'h18
`define BJX_OP_JUMP_LINK_REG       6'h19
`define BJX_OP_JUMP_LINK_REG_BARRIER  6'h1a
`define BJX_OP_JUMP_LINK_REG_COMPACT  6'h1b
`define BJX_OP_JUMP_REG            6'h1c
`define BJX_OP_JUMP_REG_BARRIER    6'h1d
`define BJX_OP_JUMP_REG_COMPACT    6'h1e
`define BJX_OP_LOAD_BYTE_SIGNED    6'h1f
`define BJX_OP_DEBUG_ENTRY         6'h20

`define BJX_LINK_REG_NUM           5'h1f
`define BJX_LINK_OFS_DELAY         32'h0000_0008
`define BJX_LINK_OFS_COMPACT       32'h0000_0002
`define BJX_SLOT_OFS               32'h0000_0004
`define BJX_SR_IE_BIT              0
`define BJX_SR_EXL_BIT             1
`define BJX_SR_ERL_BIT             2
`define BJX_SR_RESET               32'h0000_0004
`define BJX_HAZARD_CYCLES          3'h3

`endif
